// File: design/irs_ref_select.sv
// Reference input select, glitch-free mux, buffer controls and PLL dividers
`timescale 1ns/1ns
module irs_ref_select (
   input wire logic hclk, // System clock, 25 MHz
   input wire logic hresetn, // Asynchronous reset, active low
   input wire logic hsel, // Slave select
   input wire logic [31:0] haddr, // Byte address
   input wire logic [1:0] htrans, // Transfer type
   input wire logic hwrite, // Write when high
   input wire logic [2:0] hsize, // Transfer size, word only
   input wire logic [31:0] hwdata, // Write data
   input wire logic hready, // Bus ready in
   output logic [31:0] hrdata, // Read data
   output logic hreadyout, // Slave ready
   output logic hresp, // Always OKAY
   input wire logic primary_clk, // Primary reference input
   input wire logic secondary_clk, // Secondary reference input
   input wire logic feedback_clk, // PLL feedback clock
   input wire logic [1:0] reference_select_pin, // Three-level select pin code
   output logic ref_clk_out, // Muxed reference
   output logic ref_div_clk, // Reference after R divider
   output logic fb_div_clk, // Feedback after M divider
   output logic active_secondary, // Secondary is the current source
   output logic ref_mux_bypass, // Mux bypass control
   output logic primary_buffer_gain, // 1 maximum gain
   output logic secondary_buffer_gain, // 1 maximum gain
   output logic [1:0] secondary_buffer_mode, // Secondary buffer mode
   output logic secondary_buffer_enable // Secondary buffer powered
);
   import irs_pkg::*;

   logic [7:0] input_select;
   logic [7:0] input_clock_control;
   logic [IRS_REF_DIV_W-1:0] ref_divide_code;
   logic [IRS_FB_DIV_W-1:0] feedback_divide_code;
   logic [1:0] reference_source_select;
   logic secondary_xtal_hold;
   logic [5:0] data_index;
   logic data_write;
   logic read_wait;
   logic [4:0] sync1;
   logic [4:0] sync2;
   logic [2:0] last;
   logic pri_s;
   logic sec_s;
   logic fb_s;
   logic [1:0] pin_s;
   logic [IRS_LOS_W-1:0] pri_idle;
   logic [IRS_LOS_W-1:0] sec_idle;
   logic pri_ok;
   logic sec_ok;
   logic want_secondary;
   irs_mux_state_t mux_state;
   logic xtal_off;
   logic [IRS_REF_DIV_W-1:0] ref_cnt;
   logic [IRS_FB_DIV_W-1:0] fb_cnt;
   logic ref_last;

   // Next count of an N+1 divider on a rising input edge
   function automatic logic [4:0] div_step(input logic [4:0] cnt, input logic [4:0] code);
      div_step = (cnt >= code) ? 5'h0_0 : 5'(cnt + 5'h0_1);
   endfunction : div_step

   // High for the first half of the divide period
   function automatic logic div_level(input logic [4:0] cnt, input logic [4:0] code);
      logic [5:0] half;
      half = 6'(({1'b0, code} + 6'h0_2) >> 1);
      div_level = ({1'b0, cnt} < half);
   endfunction : div_level

   function automatic logic [7:0] read_mux(input logic [5:0] idx, input logic [7:0] sel,
      input logic [7:0] ctl, input logic [7:0] rdv, input logic [7:0] mdv,
      input logic [7:0] st);
      case (idx)
         IRS_IDX_INPUT_SELECT: read_mux = sel;
         IRS_IDX_INPUT_CLOCK_CONTROL: read_mux = ctl;
         IRS_IDX_REFERENCE_DIVIDER: read_mux = rdv;
         IRS_IDX_FEEDBACK_DIVIDER: read_mux = mdv;
         IRS_IDX_STATUS: read_mux = st;
         default: read_mux = 8'h0_0;
      endcase
   endfunction : read_mux

   assign reference_source_select = input_select[IRS_POS_SRC_SEL +: 2];
   assign secondary_buffer_mode = input_select[IRS_POS_SEC_MODE +: 2];
   assign ref_mux_bypass = input_clock_control[IRS_BIT_MUX_BYPASS];
   assign secondary_xtal_hold = input_clock_control[IRS_BIT_XTAL_HOLD];
   assign secondary_buffer_gain = input_clock_control[IRS_BIT_SEC_GAIN];
   assign primary_buffer_gain = input_clock_control[IRS_BIT_PRI_GAIN];
   assign hresp = 1'b0;
   assign hreadyout = !read_wait;

   // Bus address phase capture; reads take one wait state for a registered answer
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         data_index <= 6'h0_0;
         data_write <= 1'b0;
         read_wait <= 1'b0;
      end else begin
         read_wait <= 1'b0;
         data_write <= 1'b0;
         if (hready && hsel && htrans[1]) begin
            data_index <= haddr[7:2];
            data_write <= hwrite && (haddr[31:8] == 24'h00_0000);
            read_wait <= !hwrite;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (read_wait) begin
         hrdata <= {24'h00_0000, read_mux(data_index, input_select, input_clock_control,
            {5'h0_0, ref_divide_code}, {3'h0, feedback_divide_code},
            {4'h0, xtal_off, mux_state != IRS_MUX_RUN, secondary_buffer_enable,
             active_secondary})};
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         input_select <= IRS_RST_INPUT_SELECT;
         input_clock_control <= IRS_RST_INPUT_CLOCK_CONTROL;
         ref_divide_code <= IRS_RST_REF_DIVIDE;
         feedback_divide_code <= IRS_RST_FB_DIVIDE;
      end else if (data_write) begin
         case (data_index)
            IRS_IDX_INPUT_SELECT: input_select <= hwdata[7:0];
            IRS_IDX_INPUT_CLOCK_CONTROL: input_clock_control <= hwdata[7:0];
            IRS_IDX_REFERENCE_DIVIDER: ref_divide_code <= hwdata[IRS_REF_DIV_W-1:0];
            IRS_IDX_FEEDBACK_DIVIDER: feedback_divide_code <= hwdata[IRS_FB_DIV_W-1:0];
            default: ;
         endcase
      end
   end

   // Pins are asynchronous to hclk; only the second stage is read
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1 <= 5'h0_0;
         sync2 <= 5'h0_0;
         last <= 3'h0;
      end else begin
         sync1 <= {reference_select_pin, feedback_clk, secondary_clk, primary_clk};
         sync2 <= sync1;
         last <= sync2[2:0];
      end
   end
   assign pri_s = sync2[0];
   assign sec_s = sync2[1];
   assign fb_s = sync2[2];
   assign pin_s = sync2[4:3];

   // Activity monitors feeding automatic selection
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pri_idle <= '0;
         sec_idle <= '0;
      end else begin
         if (pri_s != last[0])
            pri_idle <= '0;
         else if (pri_idle < IRS_LOS_W'(IRS_LOS_CYCLES))
            pri_idle <= IRS_LOS_W'(pri_idle + 1'b1);
         if (sec_s != last[1])
            sec_idle <= '0;
         else if (sec_idle < IRS_LOS_W'(IRS_LOS_CYCLES))
            sec_idle <= IRS_LOS_W'(sec_idle + 1'b1);
      end
   end
   assign pri_ok = pri_idle < IRS_LOS_W'(IRS_LOS_CYCLES);
   assign sec_ok = sec_idle < IRS_LOS_W'(IRS_LOS_CYCLES);

   always_comb begin
      case (reference_source_select)
         IRS_SRC_PRIMARY: want_secondary = 1'b0;
         IRS_SRC_SECONDARY: want_secondary = 1'b1;
         IRS_SRC_PIN: begin
            if (pin_s == 2'h0)
               want_secondary = 1'b0;
            else if (pin_s == IRS_PIN_SECONDARY)
               want_secondary = 1'b1;
            else
               want_secondary = !pri_ok && sec_ok;
         end
         default: want_secondary = !pri_ok && sec_ok;
      endcase
   end

   // without bypass, switch only after old source low, then new source low; bypass switches at once
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mux_state <= IRS_MUX_RUN;
         active_secondary <= 1'b0;
         ref_clk_out <= 1'b0;
      end else begin
         case (mux_state)
            IRS_MUX_RUN: begin
               if (ref_mux_bypass) begin
                  active_secondary <= want_secondary;
                  ref_clk_out <= want_secondary ? sec_s : pri_s;
               end else if (want_secondary != active_secondary) begin
                  mux_state <= IRS_MUX_DRAIN_OLD;
                  ref_clk_out <= active_secondary ? sec_s : pri_s;
               end else begin
                  ref_clk_out <= active_secondary ? sec_s : pri_s;
               end
            end
            IRS_MUX_DRAIN_OLD: begin
               if (!(active_secondary ? sec_s : pri_s)) begin
                  ref_clk_out <= 1'b0;
                  active_secondary <= want_secondary;
                  mux_state <= IRS_MUX_WAIT_NEW;
               end else begin
                  ref_clk_out <= 1'b1;
               end
            end
            IRS_MUX_WAIT_NEW: begin
               ref_clk_out <= 1'b0;
               // Resume on a falling edge of the new source so its low phase stays whole;
               // a dead new source held low is let through to avoid hanging here
               if (active_secondary ? (!sec_s && (last[1] || !sec_ok)) :
                   (!pri_s && (last[0] || !pri_ok)))
                  mux_state <= IRS_MUX_RUN;
            end
            default: mux_state <= IRS_MUX_RUN;
         endcase
      end
   end

   // crystal buffer off after a switchback through the glitch-free mux unless held
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         xtal_off <= 1'b0;
      end else if (want_secondary || secondary_xtal_hold) begin
         xtal_off <= 1'b0;
      end else if (mux_state == IRS_MUX_WAIT_NEW && !active_secondary) begin
         xtal_off <= 1'b1;
      end
   end

   // mode decides buffer power; only crystal mode obeys the hold bit
   assign secondary_buffer_enable = (secondary_buffer_mode != IRS_SEC_DISABLED) &&
      !(secondary_buffer_mode == IRS_SEC_CRYSTAL && xtal_off);

   // reference divider by code plus one
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ref_cnt <= '0;
         ref_last <= 1'b0;
         ref_div_clk <= 1'b0;
      end else begin
         ref_last <= ref_clk_out;
         if (ref_clk_out && !ref_last)
            ref_cnt <= IRS_REF_DIV_W'(div_step({2'h0, ref_cnt}, {2'h0, ref_divide_code}));
         if (ref_divide_code == IRS_RST_REF_DIVIDE)
            ref_div_clk <= ref_clk_out;
         else
            ref_div_clk <= div_level({2'h0, ref_cnt}, {2'h0, ref_divide_code});
      end
   end

   // feedback divider by code plus one
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fb_cnt <= '0;
         fb_div_clk <= 1'b0;
      end else begin
         if (fb_s && !last[2])
            fb_cnt <= div_step(fb_cnt, feedback_divide_code);
         if (feedback_divide_code == IRS_RST_FB_DIVIDE)
            fb_div_clk <= fb_s;
         else
            fb_div_clk <= div_level(fb_cnt, feedback_divide_code);
      end
   end
endmodule : irs_ref_select

// File: design/irs_pkg.sv
// Register map, field layout and constants for the reference select block
// Operation
// - Bypass bit skips glitch-free reference multiplexer
// - Hold bit keeps crystal buffer after switchback
// - Secondary buffer gain: 0 minimum, 1 maximum
// - Primary buffer gain select, resets to maximum
// - Reference divider code 0 bypass, else N+1
// - Feedback divider code 0 bypass, else N+1
// - Source select: auto, pin, primary, secondary
// - Secondary mode: single, differential, crystal, disabled
package irs_pkg;
   // Register indices; byte address is four times the index
   localparam logic [5:0] IRS_IDX_INPUT_SELECT = 6'h32;
   localparam logic [5:0] IRS_IDX_INPUT_CLOCK_CONTROL = 6'h33;
   localparam logic [5:0] IRS_IDX_REFERENCE_DIVIDER = 6'h34;
   localparam logic [5:0] IRS_IDX_FEEDBACK_DIVIDER = 6'h35;
   localparam logic [5:0] IRS_IDX_STATUS = 6'h36;

   // Reset values
   localparam logic [7:0] IRS_RST_INPUT_SELECT = 8'h81;
   localparam logic [7:0] IRS_RST_INPUT_CLOCK_CONTROL = 8'h03;
   localparam logic [2:0] IRS_RST_REF_DIVIDE = 3'h0;
   localparam logic [4:0] IRS_RST_FB_DIVIDE = 5'h00;

   // Field positions
   localparam int IRS_BIT_MUX_BYPASS = 7;
   localparam int IRS_BIT_XTAL_HOLD = 2;
   localparam int IRS_BIT_SEC_GAIN = 1;
   localparam int IRS_BIT_PRI_GAIN = 0;
   localparam int IRS_POS_SEC_MODE = 6;
   localparam int IRS_POS_SRC_SEL = 0;
   localparam int IRS_REF_DIV_W = 3;
   localparam int IRS_FB_DIV_W = 5;

   // Reference source selection codes
   localparam logic [1:0] IRS_SRC_AUTO = 2'h0;
   localparam logic [1:0] IRS_SRC_PIN = 2'h1;
   localparam logic [1:0] IRS_SRC_PRIMARY = 2'h2;
   localparam logic [1:0] IRS_SRC_SECONDARY = 2'h3;

   // Secondary buffer modes
   localparam logic [1:0] IRS_SEC_SINGLE = 2'h0;
   localparam logic [1:0] IRS_SEC_DIFF = 2'h1;
   localparam logic [1:0] IRS_SEC_CRYSTAL = 2'h2;
   localparam logic [1:0] IRS_SEC_DISABLED = 2'h3;

   // Select pin levels: 0 primary, 1 mid level secondary, 2 or 3 automatic
   localparam logic [1:0] IRS_PIN_SECONDARY = 2'h1;

   // Loss-of-activity window for automatic selection
   localparam int IRS_CLK_MHZ = 25;
   localparam int IRS_LOS_NS = 640;
   localparam int IRS_LOS_CYCLES = (IRS_LOS_NS * IRS_CLK_MHZ) / 1000;
   localparam int IRS_LOS_W = 5;

   typedef enum logic [1:0] {
      IRS_MUX_RUN,
      IRS_MUX_DRAIN_OLD,
      IRS_MUX_WAIT_NEW
   } irs_mux_state_t;
endpackage : irs_pkg

// File: sim/irs_ref_select_monitor.sv
// Port-level assertions for the reference select block
`timescale 1ns/1ns
module irs_ref_select_monitor
   import irs_pkg::*;
(
   input wire logic hclk, // Clock
   input wire logic hresetn, // Reset, active low
   input wire logic hsel, // Select
   input wire logic [31:0] haddr, // Address
   input wire logic [1:0] htrans, // Transfer type
   input wire logic hwrite, // Write
   input wire logic [31:0] hwdata, // Write data
   input wire logic hready, // Bus ready
   input wire logic hreadyout, // Slave ready
   input wire logic hresp, // Response
   input wire logic ref_clk_out, // Muxed reference
   input wire logic ref_mux_bypass, // Bypass level
   input wire logic primary_buffer_gain, // Primary gain
   input wire logic secondary_buffer_gain, // Secondary gain
   input wire logic [1:0] secondary_buffer_mode, // Secondary mode
   input wire logic secondary_buffer_enable // Secondary powered
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   localparam logic [31:0] CTL_ADDR = {24'h0, IRS_IDX_INPUT_CLOCK_CONTROL, 2'h0};
   sequence req_s; hsel && hready && htrans[1]; endsequence
   sequence rd_s; req_s ##0 !hwrite; endsequence
   sequence wr_s; req_s ##0 hwrite; endsequence
   sequence ctl_s; wr_s ##0 (haddr == CTL_ADDR) ##1 hready; endsequence
   resp_okay_a: assert property (hresp == 1'b0) else $error("response not okay");
   read_wait_a: assert property (rd_s |=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
   write_nowait_a: assert property (wr_s |=> hreadyout) else $error("write stalled");
   bypass_bit_a: assert property (ctl_s |=> ref_mux_bypass == $past(hwdata[7]))
      else $error("bypass not applied");
   sec_gain_a: assert property (ctl_s |=> secondary_buffer_gain == $past(hwdata[1]))
      else $error("secondary gain not applied");
   pri_gain_a: assert property (ctl_s |=> primary_buffer_gain == $past(hwdata[0]))
      else $error("primary gain not applied");
   mode_off_a: assert property (secondary_buffer_mode == 2'h3 |-> !secondary_buffer_enable)
      else $error("disabled buffer powered");
   mode_on_a: assert property (!secondary_buffer_mode[1] |-> secondary_buffer_enable)
      else $error("buffer off in input mode");
   // Sources in the bench keep phases of at least three cycles
   high_phase_a: assert property ($rose(ref_clk_out) && !ref_mux_bypass |=> ref_clk_out [*2])
      else $error("short high phase");
   low_phase_a: assert property ($fell(ref_clk_out) && !ref_mux_bypass |=> !ref_clk_out [*2])
      else $error("short low phase");
endmodule : irs_ref_select_monitor
bind irs_ref_select irs_ref_select_monitor irs_ref_select_monitor_i (.hclk(hclk),
   .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .ref_clk_out(ref_clk_out), .ref_mux_bypass(ref_mux_bypass),
   .primary_buffer_gain(primary_buffer_gain), .secondary_buffer_gain(secondary_buffer_gain),
   .secondary_buffer_mode(secondary_buffer_mode),
   .secondary_buffer_enable(secondary_buffer_enable));

// File: sim/irs_ref_select_tb.sv
// Self-checking bench for the reference select block
`timescale 1ns/1ns
module irs_ref_select_tb;
   import irs_pkg::*;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, primary_clk, secondary_clk;
   logic feedback_clk, ref_clk_out, ref_div_clk, fb_div_clk, active_secondary, run_p;
   logic ref_mux_bypass, primary_buffer_gain, secondary_buffer_gain, secondary_buffer_enable;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans, reference_select_pin, secondary_buffer_mode;
   logic [2:0] hsize;
   logic [7:0] mdl [0:63];
   int bad_count, checks, t, p;
   logic [1:0] sc [6] = '{2'h3, 2'h2, 2'h1, 2'h1, 2'h0, 2'h0};
   logic [5:0] pin_run_exp [6] = '{6'h05, 6'h16, 6'h17, 6'h06, 6'h16, 6'h11};
   assign hready = hreadyout;
   irs_ref_select irs_ref_select_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .primary_clk(primary_clk), .secondary_clk(secondary_clk), .feedback_clk(feedback_clk),
      .reference_select_pin(reference_select_pin), .ref_clk_out(ref_clk_out),
      .ref_div_clk(ref_div_clk), .fb_div_clk(fb_div_clk), .active_secondary(active_secondary),
      .ref_mux_bypass(ref_mux_bypass), .primary_buffer_gain(primary_buffer_gain),
      .secondary_buffer_gain(secondary_buffer_gain),
      .secondary_buffer_mode(secondary_buffer_mode),
      .secondary_buffer_enable(secondary_buffer_enable));
   initial begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end
   // Primary and feedback: six-cycle period; secondary: eight
   always @(posedge hclk) begin
      t <= t + 1;
      if (t % 3 == 2) begin
         primary_clk <= run_p & ~primary_clk;
         feedback_clk <= ~feedback_clk;
      end
      if (t % 4 == 3) secondary_clk <= ~secondary_clk;
   end
   function automatic logic [7:0] msk(input logic [5:0] i);
      case (i)
         IRS_IDX_INPUT_SELECT, IRS_IDX_INPUT_CLOCK_CONTROL: return 8'hFF;
         IRS_IDX_REFERENCE_DIVIDER: return 8'h07;
         IRS_IDX_FEEDBACK_DIVIDER: return 8'h1F;
         default: return 8'h00;
      endcase
   endfunction : msk
   task end_of_test;
      $display("checks %0d errors %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : end_of_test
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task bus(input logic w, input logic [5:0] i, input logic [31:0] d, output logic [31:0] q);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, i, 2'h0};
      hwrite <= w;
      @(negedge hclk);
      while (hreadyout !== 1'b1) @(negedge hclk);
      @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(negedge hclk);
      while (hreadyout !== 1'b1) @(negedge hclk);
      q = hrdata;
      @(posedge hclk);
   endtask : bus
   task wr(input logic [5:0] i, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, i, {24'h0, d}, q);
      mdl[i] = d & msk(i);
      // Register lands at the edge ending the data phase; let it settle
      @(posedge hclk);
   endtask : wr
   task rd(input logic [5:0] i);
      logic [31:0] q;
      bus(1'b0, i, 32'h0, q);
      chk("register", {24'h0, mdl[i]}, q);
   endtask : rd
   // Cycles between the third and fourth rising edge of a divided clock
   task per(input logic f, output int n);
      int k;
      logic s, o;
      k = 0;
      n = 0;
      o = 1'b1;
      while (k < 4) begin
         @(negedge hclk);
         s = f ? fb_div_clk : ref_div_clk;
         if (s && !o) k++;
         if (k == 3) n++;
         o = s;
      end
   endtask : per
   initial begin
      #2000000;
      bad_count++;
      end_of_test;
   end
   initial begin
      {hsel, hwrite, htrans, haddr, hwdata, hresetn, t} = '0;
      {primary_clk, secondary_clk, feedback_clk, reference_select_pin} = '0;
      hsize = 3'h2;
      run_p = 1'b1;
      void'($urandom(62931));
      for (int i = 0; i < 64; i++) mdl[i] = 8'h00;
      mdl[IRS_IDX_INPUT_SELECT] = IRS_RST_INPUT_SELECT;
      mdl[IRS_IDX_INPUT_CLOCK_CONTROL] = IRS_RST_INPUT_CLOCK_CONTROL;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk("reset gains", 32'h3, {primary_buffer_gain, secondary_buffer_gain});
      for (int i = 'h32; i < 'h36; i++) rd(6'(i));
      wr(6'h3F, 8'($urandom));
      rd(6'h3F);
      repeat (4) begin
         wr(IRS_IDX_INPUT_CLOCK_CONTROL, {1'b0, 7'($urandom)});
         rd(IRS_IDX_INPUT_CLOCK_CONTROL);
         chk("gains", mdl[8'h33][1:0], {secondary_buffer_gain, primary_buffer_gain});
      end
      wr(IRS_IDX_INPUT_CLOCK_CONTROL, 8'h83);
      chk("bypass", 32'h1, ref_mux_bypass);
      wr(IRS_IDX_INPUT_SELECT, 8'h82);
      for (int n = 0; n < 8; n++) begin
         wr(IRS_IDX_REFERENCE_DIVIDER, {5'($urandom), 3'(n)});
         rd(IRS_IDX_REFERENCE_DIVIDER);
         per(1'b0, p);
         chk("ref period", 6 * (n + 1), p);
      end
      for (int n = 0; n < 32; n++) begin
         wr(IRS_IDX_FEEDBACK_DIVIDER, {3'($urandom), 5'(n)});
         per(1'b1, p);
         chk("fb period", 6 * (n + 1), p);
      end
      for (int h = 0; h < 2; h++) begin
         wr(IRS_IDX_INPUT_CLOCK_CONTROL, {5'h0, 1'(h), 2'h3});
         for (int k = 0; k < 6; k++) begin
            reference_select_pin <= pin_run_exp[k][5:4];
            run_p <= pin_run_exp[k][2];
            wr(IRS_IDX_INPUT_SELECT, {IRS_SEC_CRYSTAL, 4'h0, sc[k]});
            repeat (60) @(posedge hclk);
            chk("source", pin_run_exp[k][0], active_secondary);
            chk("xtal on", pin_run_exp[k][0] | 1'(h), secondary_buffer_enable);
         end
      end
      run_p <= 1'b1;
      for (int m = 0; m < 4; m++) begin
         wr(IRS_IDX_INPUT_SELECT, {2'(m), 6'h02});
         chk("mode", m, secondary_buffer_mode);
         chk("sec enable", m != 3, secondary_buffer_enable);
      end
      end_of_test;
   end
endmodule : irs_ref_select_tb
